/* verilog/debug_break_counter_control.sv */
/*
  break point, break loop and debug counter control of the debug unit, with
  command gating and the automatic serial break after a clock switch while i_baud_set is high.
  assumes the serial receiver delivers whole command bytes and host breaks as
  pulses on i_clk, the transmitter drains the reply stream, and the cpu obeys
  o_cpu_halt before executing the instruction at a matched address.
*/
module debug_break_counter_control
  import debug_pkg::*;
#(
  parameter logic [7:0] REV_MAJOR = 8'h01,  // arbitrary revision value
  parameter logic [7:0] REV_MINOR = 8'h00   // arbitrary revision value
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_rx_valid,
  output logic             o_rx_ready,
  output logic [7:0]       o_tx_data,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  input  wire logic        i_host_break,
  input  wire logic        i_clk_switch,
  input  wire logic        i_baud_set,
  output logic             o_baud_reset,
  output logic             o_debug_serial_pin_oe,
  output logic             o_debug_serial_pin_out,
  input  wire logic        i_read_protect_option,
  input  wire logic        i_brk_decode,
  input  wire logic        i_instr_start,
  input  wire logic [15:0] i_pc,
  input  wire logic        i_byte_count_dec,
  output logic             o_cpu_halt,
  output logic             o_brk_enable,
  output logic             o_brk_loop,
  output logic [7:0]       o_ext_cmd,
  output logic             o_ext_cmd_valid
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CNT_HI,
    ST_CNT_LO,
    ST_CTL,
    ST_REPLY
  } cmd_state_t;

  cmd_state_t       st_reg, st_next;        // command sequencer
  logic [7:0]       ctl_reg, ctl_next;      // debug_control_reg
  logic [15:0]      cnt_reg, cnt_next;      // debug_cycle_counter (stored)
  logic             idle_reg, idle_next;    // looping on break instruction
  logic [7:0]       hi_reg, hi_next;        // high byte of counter write
  logic [15:0]      rep_reg, rep_next;      // reply bytes, high first
  logic [1:0]       rep_n_reg, rep_n_next;  // reply bytes left
  logic             rdy_reg, rdy_next;      // receiver may deliver
  logic             baud_rst_reg, baud_rst_next;
  logic [7:0]       ext_reg, ext_next;      // forwarded command byte
  logic             extv_reg, extv_next;    // forwarded command strobe
  logic             brk_start;              // launch outgoing break
  logic             brk_active;             // break timer running
  logic             halt;                   // in debug mode
  logic             cmd_open;               // full command set usable
  logic             enter_dbg;              // any hardware debug entry event
  logic             ctl_wr;                 // control write this cycle
  logic             cnt_wr;                 // counter load this cycle
  logic [15:0]      cnt_wr_val;             // counter load value
  logic [7:0]       stat_val;               // debug_status_reg view
  cnt_mode_t        mode;                   // counter mode from control

  stream_if #(.WIDTH(DATA_W)) rep_s ();     // command logic to buffer
  stream_if #(.WIDTH(DATA_W)) tx_s ();      // buffer to transmitter

  assign halt = ctl_reg[CTL_HALT_BIT];
  assign mode = cnt_mode_t'(ctl_reg[CTL_MODE_LSB +: 2]);
  assign cmd_open = halt;

  // status view: halt, idle, read protect
  always_comb begin
    stat_val = 8'h00;
    stat_val[STAT_HALT_BIT] = halt;
    stat_val[STAT_IDLE_BIT] = idle_reg;
    stat_val[STAT_RP_BIT] = i_read_protect_option;
  end

  // reply stream: one byte offered while in the reply state
  // whole bytes only
  assign rep_s.data = rep_reg[15:8];
  assign rep_s.valid = (st_reg == ST_REPLY);
  assign tx_s.ready = i_tx_ready;

  // outputs come straight from flip-flops, except the serial pin data, which is tied low
  assign o_rx_ready = rdy_reg;
  assign o_tx_data = tx_s.data;
  assign o_tx_valid = tx_s.valid;
  assign o_baud_reset = baud_rst_reg;
  assign o_debug_serial_pin_oe = brk_active;
  assign o_debug_serial_pin_out = 1'b0;  // open drain: only ever pulls low
  assign o_cpu_halt = ctl_reg[CTL_HALT_BIT];
  assign o_brk_enable = ctl_reg[CTL_BRK_EN_BIT];
  assign o_brk_loop = ctl_reg[CTL_LOOP_BIT];
  assign o_ext_cmd = ext_reg;
  assign o_ext_cmd_valid = extv_reg;

  assign brk_start = i_clk_switch && i_baud_set;

  // command sequencer; host break and clock switch with i_baud_set abort any command
  always_comb begin
    st_next = st_reg;
    hi_next = hi_reg;
    rep_next = rep_reg;
    rep_n_next = rep_n_reg;
    ext_next = ext_reg;
    extv_next = 1'b0;
    ctl_wr = 1'b0;
    cnt_wr = 1'b0;
    cnt_wr_val = {hi_reg, i_rx_data};
    baud_rst_next = i_host_break || brk_start;
    if (i_host_break || brk_start) begin
      st_next = ST_IDLE;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (i_rx_valid) begin
            case (i_rx_data)
              CMD_READ_REV: begin
                rep_next = {REV_MAJOR, REV_MINOR};
                rep_n_next = 2'd2;
                st_next = ST_REPLY;
              end
              CMD_WRITE_CNT: st_next = ST_CNT_HI;
              CMD_READ_STAT: begin
                rep_next = {stat_val, 8'h00};
                rep_n_next = 2'd1;
                st_next = ST_REPLY;
              end
              CMD_READ_CNT: begin
                rep_next = cmd_open ? ~cnt_reg : CNT_LOCKED;
                rep_n_next = 2'd2;
                st_next = ST_REPLY;
              end
              CMD_WRITE_CTL: st_next = ST_CTL;
              CMD_READ_CTL: begin
                rep_next = {ctl_reg, 8'h00};
                rep_n_next = 2'd1;
                st_next = ST_REPLY;
              end
              default: begin
                if (cmd_open && !(i_read_protect_option &&
                                  cmd_code_protected(i_rx_data))) begin
                  ext_next = i_rx_data;
                  extv_next = 1'b1;
                end
              end
            endcase
          end
        end
        ST_CNT_HI: begin
          if (i_rx_valid) begin
            hi_next = i_rx_data;
            st_next = ST_CNT_LO;
          end
        end
        ST_CNT_LO: begin
          if (i_rx_valid) begin
            cnt_wr = cmd_open;
            st_next = ST_IDLE;
          end
        end
        ST_CTL: begin
          if (i_rx_valid) begin
            ctl_wr = 1'b1;
            st_next = ST_IDLE;
          end
        end
        ST_REPLY: begin
          if (rep_s.ready) begin
            rep_next = {rep_reg[7:0], 8'h00};
            rep_n_next = rep_n_reg - 2'd1;
            if (rep_n_reg == 2'd1) begin
              st_next = ST_IDLE;
            end
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
    // receiver stalls while a reply is queued
    rdy_next = (st_next != ST_REPLY);
  end

  // break point and counter events, debug entry and exit
  always_comb begin
    enter_dbg = 1'b0;
    idle_next = idle_reg;
    if (i_brk_decode && ctl_reg[CTL_BRK_EN_BIT] && !halt) begin
      if (ctl_reg[CTL_LOOP_BIT]) begin
        idle_next = 1'b1;
      end else begin
        enter_dbg = 1'b1;
      end
    end
    if (!halt && mode == CNT_ADDR_MATCH && i_instr_start && i_pc == cnt_reg) begin
      enter_dbg = 1'b1;
    end
    if (!halt && mode == CNT_DOWN_BRK && cnt_reg == CNT_ZERO) begin
      enter_dbg = 1'b1;
    end
    if (!ctl_reg[CTL_BRK_EN_BIT] || halt || enter_dbg) begin
      idle_next = 1'b0;
    end
    // control write, hardware entry sets halt on top
    ctl_next = ctl_wr ? i_rx_data : ctl_reg;
    if (enter_dbg) begin
      ctl_next[CTL_HALT_BIT] = 1'b1;
    end
  end

  // debug counter: loads, byte counting, cycle and countdown decrement
  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_wr) begin
      cnt_next = cnt_wr_val;
    end else if (halt && i_byte_count_dec && cnt_reg != CNT_ZERO) begin
      cnt_next = cnt_reg - 16'h0001;
    end else if (halt && !ctl_next[CTL_HALT_BIT] && mode == CNT_CYCLE) begin
      cnt_next = CNT_MAX;
    end else if (!halt && cnt_reg != CNT_ZERO &&
                 (mode == CNT_CYCLE || mode == CNT_DOWN_BRK)) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  // all state of this module
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= ST_IDLE;
      ctl_reg <= CTL_RESET;
      cnt_reg <= CNT_RESET;
      idle_reg <= 1'b0;
      hi_reg <= 8'h00;
      rep_reg <= 16'h0000;
      rep_n_reg <= 2'd0;
      rdy_reg <= 1'b0;
      baud_rst_reg <= 1'b0;
      ext_reg <= 8'h00;
      extv_reg <= 1'b0;
    end else if (i_ce) begin
      st_reg <= st_next;
      ctl_reg <= ctl_next;
      cnt_reg <= cnt_next;
      idle_reg <= idle_next;
      hi_reg <= hi_next;
      rep_reg <= rep_next;
      rep_n_reg <= rep_n_next;
      rdy_reg <= rdy_next;
      baud_rst_reg <= baud_rst_next;
      ext_reg <= ext_next;
      extv_reg <= extv_next;
    end
  end

  // reply buffer; its full flag stalls the sequencer in the reply state
  reply_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_reply_fifo (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .in_s  (rep_s),
    .out_s (tx_s)
  );

  serial_break_gen u_break (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_ce     (i_ce),
    .i_start  (brk_start),
    .o_active (brk_active)
  );
endmodule

/* verilog/debug_pkg.sv */
/*
  shared constants for the debug break / counter control block: command codes,
  control and status bit positions, counter modes, reset values and counts.
  assumes every user module imports the whole package.
*/
// Notes on behaviour
// - clock switch voids held baud value
// - clock switch: 4096-clock break, baud reset
// - enabled break opcode idles cpu, debug mode
// - disabled break opcode ignored, acts as nop
// - loop option keeps cpu servicing interrupts, dma
// - status idle bit set while looping
// - loop cleared: next break enters debug
// - looping cpu sees restricted command set
// - cycle mode counts outside debug, stops max
// - cycle mode counter cleared on debug exit
// - countdown mode breaks at zero, keeps value
// - match mode breaks when pc equals counter
// - counter counts bytes, keeps residual value
// - counter always read back inverted
// - counter only ever decrements
// - outside debug only command subset accepted
// - read protect blocks code exposing commands
// - 00h revision, 02h status always accepted
// - 01h, 03h counter commands need debug
// - character: start, 8 data lsb first, stop
// - host break resets baud only; the code also returns the command sequencer to idle
// - counter write: high byte first, else discarded
package debug_pkg;
  localparam int DATA_W = 8;                  // command / reply byte width
  localparam int CNT_W = 16;                  // debug counter width
  localparam int FIFO_DEPTH = 4;              // reply buffer depth
  localparam int BREAK_CLOCKS = 4096;         // outgoing serial break length
  localparam int BREAK_W = 13;                // holds BREAK_CLOCKS

  localparam logic [7:0] CMD_READ_REV = 8'h00;
  localparam logic [7:0] CMD_WRITE_CNT = 8'h01;
  localparam logic [7:0] CMD_READ_STAT = 8'h02;
  localparam logic [7:0] CMD_READ_CNT = 8'h03;
  localparam logic [7:0] CMD_WRITE_CTL = 8'h04;
  localparam logic [7:0] CMD_READ_CTL = 8'h05;

  // control register bit positions
  localparam int CTL_HALT_BIT = 7;            // debug_halt_flag
  localparam int CTL_BRK_EN_BIT = 6;          // break points enabled
  localparam int CTL_LOOP_BIT = 5;            // break_loop_select
  localparam int CTL_MODE_LSB = 3;            // two-bit counter mode
  localparam logic [7:0] CTL_RESET = 8'h00;

  // status register bit positions
  localparam int STAT_HALT_BIT = 7;
  localparam int STAT_IDLE_BIT = 6;
  localparam int STAT_RP_BIT = 5;

  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;   // cycle count start, reads 0000h
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_LOCKED = 16'hffff; // counter read outside debug

  typedef enum logic [1:0] {
    CNT_OFF,
    CNT_CYCLE,
    CNT_DOWN_BRK,
    CNT_ADDR_MATCH
  } cnt_mode_t;

  // codes that reveal or alter code memory
  function automatic logic cmd_code_protected(input logic [7:0] code);
    cmd_code_protected = (code == 8'h06) || (code == 8'h07) || (code == 8'h0a) ||
                         (code == 8'h0b) || (code == 8'h0c) || (code == 8'h0d) ||
                         (code == 8'h10) || (code == 8'h11) || (code == 8'h12);
  endfunction
endpackage

/* verilog/stream_if.sv */
/*
  valid / ready byte stream from the command logic to the reply buffer and from the buffer to the transmitter.
  assumes both ends sit on the same clock.
*/
interface stream_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] data;   // payload
  logic             valid;  // source offers data
  logic             ready;  // sink takes data
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* verilog/reply_fifo.sv */
/*
  small reply buffer with a registered output stage.
  assumes a power-of-two depth and one clock.
*/
module reply_fifo
  import debug_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];    // storage words
  logic [AW-1:0]    wr_reg, wr_next;    // write pointer
  logic [AW-1:0]    rd_reg, rd_next;    // read pointer
  logic [AW:0]      cnt_reg, cnt_next;  // words held in storage
  logic [WIDTH-1:0] out_reg, out_next;  // output stage data
  logic             ov_reg, ov_next;    // output stage valid
  logic             push;
  logic             pull;

  // full refuses the writer, so back-pressure reaches the command logic
  assign in_s.ready = (cnt_reg != (AW + 1)'(DEPTH));
  assign out_s.data = out_reg;
  assign out_s.valid = ov_reg;

  // pointer, count and output stage next values
  always_comb begin
    push = in_s.valid && in_s.ready;
    pull = (!ov_reg || out_s.ready) && (cnt_reg != '0);
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pull ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};
    out_next = pull ? mem_reg[rd_reg] : out_reg;
    if (pull) begin
      ov_next = 1'b1;
    end else if (out_s.ready) begin
      ov_next = 1'b0;
    end else begin
      ov_next = ov_reg;
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      out_reg <= '0;
      ov_reg <= 1'b0;
    end else if (i_ce) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      ov_reg <= ov_next;
    end
  end

  // storage words, no reset needed
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem_reg[wr_reg] <= in_s.data;
    end
  end
endmodule

/* verilog/serial_break_gen.sv */
/*
  holds the debug pin low for a fixed number of clocks after a start pulse.
  assumes the start pulse is synchronous to i_clk.
*/
module serial_break_gen
  import debug_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_start,
  output logic      o_active
);
  logic [BREAK_W-1:0] left_reg, left_next;  // clocks of break remaining
  logic               act_reg, act_next;    // break being driven

  assign o_active = act_reg;

  // a new start restarts the full length
  always_comb begin
    if (i_start) begin
      left_next = BREAK_W'(BREAK_CLOCKS);
    end else if (left_reg != '0) begin
      left_next = left_reg - 1'b1;
    end else begin
      left_next = left_reg;
    end
    act_next = (left_next != '0);
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      left_reg <= '0;
      act_reg <= 1'b0;
    end else if (i_ce) begin
      left_reg <= left_next;
      act_reg <= act_next;
    end
  end
endmodule

/* bench/debug_host_model.sv */
/*
  host debugger model on the far side of the command and reply byte streams.
  assumes the device's own receiver and transmitter do the serial framing.
*/
module debug_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_stall,
  input  wire logic       i_rx_ready,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];  // reply bytes heard, oldest first
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
  end
  // a slow host stalls the replies now and then
  assign o_tx_ready = !i_stall;
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) rx_q.push_back(i_tx_data);
  end
  // one byte offered after an edge, held until the device takes it
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_rx_data <= b;
    o_rx_valid <= 1'b1;
    do @(posedge i_clk); while (!i_rx_ready);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~b;  // released line never repeats
  endtask
endmodule

/* bench/debug_break_counter_control_props.sv */
/*
  checker for the debug break and counter control block.
  assumes one clock and a synchronous active-high reset; bound to the top.
*/
module debug_break_counter_control_props (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_ce,
  input wire logic [7:0] i_rx_data,
  input wire logic       i_rx_valid,
  input wire logic       o_rx_ready,
  input wire logic [7:0] o_tx_data,
  input wire logic       o_tx_valid,
  input wire logic       i_tx_ready,
  input wire logic       i_host_break,
  input wire logic       i_clk_switch,
  input wire logic       i_baud_set,
  input wire logic       o_baud_reset,
  input wire logic       o_debug_serial_pin_oe,
  input wire logic       i_brk_decode,
  input wire logic       o_cpu_halt,
  input wire logic       o_brk_enable,
  input wire logic       o_brk_loop
);
  logic [13:0] brk_len_reg;  // break cycles so far
  logic [13:0] brk_len_next;
  // count while the pin is pulled low, hold while frozen
  always_comb begin
    brk_len_next = brk_len_reg;
    if (!o_debug_serial_pin_oe) brk_len_next = 14'h0000;
    else if (i_ce) brk_len_next = brk_len_reg + 14'h0001;
  end
  always_ff @(posedge i_clk) begin
    brk_len_reg <= i_rst ? 14'h0000 : brk_len_next;
  end
  logic [1:0] arg_reg;  // argument bytes owed
  always_ff @(posedge i_clk) begin
    if (i_rst || i_host_break || (i_clk_switch && i_baud_set)) arg_reg <= 2'h0;
    else if (i_ce && i_rx_valid && o_rx_ready)
      arg_reg <= |arg_reg ? arg_reg - 2'h1 : {i_rx_data == 8'h01, i_rx_data == 8'h04};
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // a revision or status command taken by the sequencer
  sequence reply_cmd;
    i_ce && i_rx_valid && o_rx_ready && arg_reg == 2'h0 && (i_rx_data & 8'hfd) == 8'h00;
  endsequence
  // a clock switch seen while no break is running
  sequence switch_idle;
    i_ce && i_clk_switch && !i_host_break && !o_debug_serial_pin_oe;
  endsequence
  chk_break_start:
    assert property (switch_idle ##0 i_baud_set |=> o_baud_reset && o_debug_serial_pin_oe)
    else $error("clock switch gave no break");
  chk_break_none:
    assert property (switch_idle ##0 !i_baud_set |=> !o_debug_serial_pin_oe)
    else $error("break sent without a baud value");
  chk_break_span:
    assert property ($fell(o_debug_serial_pin_oe) && !$past(i_rst) |-> brk_len_reg == 14'h1000)
    else $error("outgoing break length wrong");
  chk_break_bound:
    assert property (o_debug_serial_pin_oe |-> brk_len_reg < 14'h1000)
    else $error("outgoing break too long");
  chk_host_baud:
    assert property (i_ce && i_host_break |=> o_baud_reset)
    else $error("host break gave no baud reset");
  chk_brk_enter:
    assert property (i_ce && i_brk_decode && o_brk_enable && !o_brk_loop && !o_cpu_halt
                     |=> o_cpu_halt)
    else $error("enabled break did not halt");
  chk_reply_wait:
    assert property (reply_cmd |=> !o_rx_ready ##[0:3] o_tx_valid)
    else $error("reply not offered in time");
  chk_tx_hold:
    assert property (i_ce && o_tx_valid && !i_tx_ready && !i_host_break
                     |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply byte dropped before taken");
endmodule
bind debug_break_counter_control debug_break_counter_control_props i_props (
  .i_clk, .i_rst, .i_ce, .i_rx_data, .i_rx_valid, .o_rx_ready, .o_tx_data, .o_tx_valid,
  .i_tx_ready, .i_host_break, .i_clk_switch, .i_baud_set, .o_baud_reset,
  .o_debug_serial_pin_oe, .i_brk_decode, .o_cpu_halt, .o_brk_enable, .o_brk_loop);

/* bench/debug_break_counter_control_tb.sv */
/*
  self-checking bench for the debug break and counter control block.
  assumes the host model feeds whole bytes and the checker is bound.
*/
module debug_break_counter_control_tb
  import debug_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV_A = 8'h5a;  // arbitrary revision value
  localparam logic [7:0] REV_B = 8'hc3;  // arbitrary revision value
  logic        i_clk, i_rst, i_ce, i_rx_valid, o_rx_ready, o_tx_valid, i_tx_ready;
  logic        i_host_break, i_clk_switch, i_baud_set, o_baud_reset, o_debug_serial_pin_oe;
  logic        i_read_protect_option, i_brk_decode, i_instr_start, i_byte_count_dec;
  logic        o_cpu_halt, o_brk_enable, o_brk_loop, o_ext_cmd_valid, stall;
  logic [7:0]  i_rx_data, o_tx_data, o_ext_cmd;
  logic [15:0] i_pc, rnd, m_cnt, v;  // rnd: lfsr, m_cnt: model counter
  logic [7:0]  prot_codes [9] = '{8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12};
  int          error_cnt, num_checks, oe_len, baud_cnt, ext_cnt, run_len, e0, r0;
  debug_break_counter_control #(.REV_MAJOR(REV_A), .REV_MINOR(REV_B)) i_dut (
    .i_clk, .i_rst, .i_ce, .i_rx_data, .i_rx_valid, .o_rx_ready, .o_tx_data, .o_tx_valid,
    .i_tx_ready, .i_host_break, .i_clk_switch, .i_baud_set, .o_baud_reset,
    .o_debug_serial_pin_oe, .o_debug_serial_pin_out(), .i_read_protect_option,
    .i_brk_decode, .i_instr_start, .i_pc, .i_byte_count_dec, .o_cpu_halt, .o_brk_enable,
    .o_brk_loop, .o_ext_cmd, .o_ext_cmd_valid);
  debug_host_model i_host (
    .i_clk, .i_stall(stall), .i_rx_ready(o_rx_ready), .o_rx_data(i_rx_data),
    .o_rx_valid(i_rx_valid), .i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid),
    .o_tx_ready(i_tx_ready));
  always #25 i_clk = ~i_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // random source and event counts seen at the ports
  always @(posedge i_clk) begin
    rnd <= lfsr(rnd);
    stall <= rnd[0] & rnd[3];  // host stalls about a quarter of the cycles
    oe_len <= oe_len + int'(o_debug_serial_pin_oe);
    baud_cnt <= baud_cnt + int'(o_baud_reset);
    ext_cnt <= ext_cnt + int'(o_ext_cmd_valid);
    run_len <= run_len + int'(!o_cpu_halt);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // counts that may drift by up to three cycles of pipeline
  task automatic near(input string what, input int exp, input int got, input int tol);
    chk(what, 16'(exp), (got - exp <= tol && exp - got <= tol) ? 16'(exp) : 16'(got));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one command and its reply, high byte first; bounded wait
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] r);
    r = 16'h0000;
    i_host.send(c);
    for (int k = 0; k < 300 && i_host.rx_q.size() < n; k++) @(posedge i_clk);
    if (i_host.rx_q.size() != n) chk("reply bytes", 16'(n), 16'(i_host.rx_q.size()));
    while (i_host.rx_q.size() > 0) r = {r[7:0], i_host.rx_q.pop_front()};
  endtask
  task automatic ctl(input logic [7:0] b);
    i_host.send(CMD_WRITE_CTL);
    i_host.send(b);
    cyc(3);
  endtask
  task automatic cnt_wr(input logic [15:0] b);
    i_host.send(CMD_WRITE_CNT);
    i_host.send(b[15:8]);
    i_host.send(b[7:0]);
    cyc(3);
  endtask
  task automatic pulse_brk();
    i_brk_decode <= 1'b1;
    @(posedge i_clk);
    i_brk_decode <= 1'b0;
    cyc(3);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a hang is cut short
  initial begin
    repeat (90000) @(posedge i_clk);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end
  initial begin
    {i_clk, i_host_break, i_clk_switch, i_baud_set, i_read_protect_option} = 5'h00;
    {i_brk_decode, i_instr_start, i_byte_count_dec, stall, i_rst, i_ce} = 6'h03;
    i_pc = 16'h0000;
    rnd = 16'h3850;  // seed 14416
    cyc(10);
    i_rst <= 1'b0;
    cyc(2);
    rd(CMD_READ_REV, 2, v);
    chk("revision", {REV_A, REV_B}, v);
    rd(CMD_READ_STAT, 1, v);
    chk("status", 16'h0000, v);
    i_read_protect_option <= 1'b1;
    rd(CMD_READ_STAT, 1, v);
    chk("status protected", 16'h0020, v);
    rd(CMD_READ_CNT, 2, v);
    chk("counter outside debug", CNT_LOCKED, v);
    i_read_protect_option <= 1'b0;
    e0 = ext_cnt;
    i_host.send(8'h08);
    cyc(4);
    chk("command outside debug", 16'(e0), 16'(ext_cnt));
    ctl(8'h80);
    m_cnt = rnd;
    cnt_wr(m_cnt);
    rd(CMD_READ_CNT, 2, v);
    chk("counter inverted", ~m_cnt, v);
    i_byte_count_dec <= 1'b1;
    cyc(3);
    i_byte_count_dec <= 1'b0;
    m_cnt = m_cnt - 16'h0003;
    ctl(8'h00);
    cnt_wr(16'h1234);
    ctl(8'h80);
    rd(CMD_READ_CNT, 2, v);
    chk("counter after bytes and discard", ~m_cnt, v);
    foreach (prot_codes[j]) begin
      for (int p = 0; p < 2; p++) begin
        i_read_protect_option <= p[0];
        e0 = ext_cnt;
        i_host.send(prot_codes[j]);
        cyc(4);
        chk("command gate", {prot_codes[j], 8'(e0 + 1 - p)}, {o_ext_cmd, 8'(ext_cnt)});
      end
    end
    i_read_protect_option <= 1'b0;
    ctl(8'h00);
    pulse_brk();
    chk("halt with breaks off", 16'h0000, 16'(o_cpu_halt));
    ctl(8'h40);
    pulse_brk();
    chk("halt on break", 16'h0001, 16'(o_cpu_halt));
    ctl(8'h60);
    pulse_brk();
    rd(CMD_READ_STAT, 1, v);
    chk("idle while looping", 16'h0040, v);
    chk("cpu runs while looping", 16'h0003, 16'({o_cpu_halt, o_brk_enable, o_brk_loop}));
    rd(CMD_READ_CNT, 2, v);
    chk("counter while looping", CNT_LOCKED, v);
    // drop loop select; the next break sets halt
    ctl(8'h40);
    pulse_brk();
    rd(CMD_READ_STAT, 1, v);
    chk("halt after loop release", 16'h0080, v);
    ctl(8'h88);
    for (int k = 0; k < 3; k++) begin
      r0 = run_len;
      ctl(8'h08);
      cyc(k == 2 ? 66000 : 120 - 90 * k);
      ctl(8'h88);
      rd(CMD_READ_CNT, 2, v);
      if (k < 2) near("cycle count", run_len - r0, int'(v), 2);
      else chk("cycle count saturates", CNT_MAX, v);
    end
    ctl(8'h90);
    cnt_wr(16'h0014);
    r0 = run_len;
    ctl(8'h10);
    for (int k = 0; k < 60 && o_cpu_halt !== 1'b1; k++) @(posedge i_clk);
    near("countdown run", 20, run_len - r0, 3);
    rd(CMD_READ_CNT, 2, v);
    chk("countdown stops at zero", 16'hffff, v);
    ctl(8'h98);
    m_cnt = rnd | 16'h0001;
    cnt_wr(m_cnt);
    ctl(8'h18);
    for (int k = 0; k < 2; k++) begin
      i_pc <= m_cnt - 16'h0001 + 16'(k);
      i_instr_start <= 1'b1;
      @(posedge i_clk);
      i_instr_start <= 1'b0;
      cyc(3);
      chk("halt on address match", 16'(k), 16'(o_cpu_halt));
    end
    rd(CMD_READ_CNT, 2, v);
    chk("match counter kept", ~m_cnt, v);
    for (int k = 0; k < 2; k++) begin
      i_baud_set <= k[0];
      r0 = oe_len;
      e0 = baud_cnt;
      i_clk_switch <= 1'b1;
      @(posedge i_clk);
      i_clk_switch <= 1'b0;
      cyc(4200);
      chk("outgoing break length", 16'(BREAK_CLOCKS * k), 16'(oe_len - r0));
      chk("baud reset on switch", 16'(k), 16'(baud_cnt - e0));
    end
    e0 = baud_cnt;
    i_host_break <= 1'b1;
    @(posedge i_clk);
    i_host_break <= 1'b0;
    cyc(3);
    chk("baud reset on host break", 16'(e0 + 1), 16'(baud_cnt));
    rd(CMD_READ_CTL, 1, v);
    chk("control kept over host break", 16'h0098, v);
    wrap_up();
  end
endmodule
